// *** logic/acmp_cfg.svh ***
// Offsets, field positions, reset values and codes of the comparator control block.
// Included by the package and the design file; holds definitions only.
`ifndef ACMP_CFG_SVH
`define ACMP_CFG_SVH

// Register byte addresses on the 32-bit bus.
`define ACMP_CTRL0_ADDR 8'h00
`define ACMP_CTRL1_ADDR 8'h04
`define ACMP_CTRL2_ADDR 8'h08
`define ACMP_CTRL3_ADDR 8'h0c
`define ACMP_STATUS_ADDR 8'h10
`define ACMP_AUX_ADDR 8'h14
`define ACMP_ADDR_W 8

// Control register fields.
`define ACMP_EN_BIT 7
`define ACMP_IE_BIT 6
`define ACMP_SENSE_HI 5
`define ACMP_SENSE_LO 4
`define ACMP_OPT_BIT 3
`define ACMP_SEL_HI 2
`define ACMP_SEL_LO 0
`define ACMP_CTRL_RESET 8'h00

// Status register fields: flags above results.
`define ACMP_FLAG_LO 4
`define ACMP_RESULT_LO 0
`define ACMP_STATUS_RESET 8'h00

// Auxiliary register fields.
`define ACMP_AUX_CAPT_MASK_BIT 0
`define ACMP_AUX_CAPT_EDGE_BIT 1
`define ACMP_AUX_REF_LO 2
`define ACMP_AUX_AMP_LO 4
`define ACMP_AUX_RESET 8'h00

// Sensitivity codes.
`define ACMP_SENSE_TOGGLE 2'h0
`define ACMP_SENSE_RSVD 2'h1
`define ACMP_SENSE_FALL 2'h2
`define ACMP_SENSE_RISE 2'h3

// Negative input selector codes.
`define ACMP_NEG_REF_D640 3'h0
`define ACMP_NEG_REF_D320 3'h1
`define ACMP_NEG_REF_D213 3'h2
`define ACMP_NEG_REF_D160 3'h3
`define ACMP_NEG_BANDGAP 3'h4
`define ACMP_NEG_DAC 3'h5
`define ACMP_NEG_PIN 3'h6
`define ACMP_NEG_RSVD 3'h7

`endif

// *** logic/acmp_pkg.sv ***
// Types shared by the comparator control block and its bench.
// Assumes the constants header sits beside it on the include path.
`include "acmp_cfg.svh"

package acmp_pkg;

  localparam int NUM_CMP = 4;
  localparam int NUM_AMP = 3;

  // One comparator control byte.
  typedef struct packed {
    logic en;
    logic ie;
    logic [1:0] sense;
    logic opt;
    logic [2:0] neg_sel;
  } cmp_ctrl_t;

  // Routing towards the timer capture front end.
  typedef struct packed {
    logic level;
    logic event_pulse;
    logic irq;
  } capture_t;

  // Auxiliary settings byte.
  typedef struct packed {
    logic rsvd;
    logic [2:0] amp_connect;
    logic [1:0] ref_sel;
    logic capt_edge;
    logic capt_mask;
  } aux_t;

endpackage : acmp_pkg

// *** logic/analog_comparator_control.sv ***
// Digital control and event logic for four clocked analog comparators.
// Assumes a classic Wishbone master, comparator outcomes and clock ticks
// that are synchronous to clk_i, and a timer capture unit outside.
//
// Summary of operation
// - Result bit high when positive exceeds selected negative.
// - Four comparators, each with its own interrupt.
// - Comparator 0 bit 3 picks PLL or I/O clock.
// - Control bit 7 enables the comparator.
// - Control bit 6 gates the interrupt request.
// - Bits 5:4 pick toggle, falling or rising edge.
// - Three-bit selector picks negative input source.
// - Reference levels derive from converter reference select.
// - Interrupt flags trigger converter and DAC conversions.
// - Comparator 1 bit 3 routes output to capture.
// - Capture interrupt only when capture mask set.
// - Capture edge bit picks rising or falling edge.
// - Routing bit clear disconnects comparator 1 from capture.
// - Amplifier connect makes comparator clock twice amplifier clock.
// - Hardware sets flag on the selected output event.
// - Flag clears on vector execution or written one.
//
// Added by the designer: the Wishbone slave port and the address map.
`timescale 1ns/100ps
`include "acmp_cfg.svh"

module analog_comparator_control
  import acmp_pkg::*;
(
  // Clock, reset and clock enable
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [`ACMP_ADDR_W-1:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Analog front end
  input wire logic [NUM_CMP-1:0] cmp_raw_i,
  output cmp_ctrl_t [NUM_CMP-1:0] cmp_ctrl_o,
  output logic [1:0] ref_sel_o,
  output logic [NUM_AMP-1:0] amp_connect_o,
  // Clock ticks
  input wire logic pll_tick_i,
  input wire logic [NUM_AMP-1:0] amp_tick2x_i,
  // Interrupt and trigger side
  input wire logic [NUM_CMP-1:0] vector_ack_i,
  output logic [NUM_CMP-1:0] irq_o,
  output logic [NUM_CMP-1:0] conv_trig_o,
  output logic [NUM_CMP-1:0] result_o,
  output capture_t capture_o
);

  cmp_ctrl_t [NUM_CMP-1:0] ctrl_ff;
  aux_t aux_ff;
  logic [NUM_CMP-1:0] result_ff;
  logic [NUM_CMP-1:0] flag_ff;
  logic [NUM_CMP-1:0] irq_ff;
  logic [NUM_CMP-1:0] trig_ff;
  logic [NUM_CMP-1:0] res_out_ff;
  cmp_ctrl_t [NUM_CMP-1:0] ctrl_out_ff;
  logic [1:0] ref_ff;
  logic [NUM_AMP-1:0] amp_ff;
  capture_t capt_ff;
  logic capt_prev_ff;
  logic div_ff;
  logic ack_ff;
  logic [31:0] dat_ff;

  logic bus_req;
  logic wr_req;
  logic base_tick;
  logic div_tick;
  logic [NUM_CMP-1:0] tick;
  logic [NUM_CMP-1:0] amp_on;
  logic [NUM_CMP-1:0] amp_tick;
  logic [NUM_CMP-1:0] active;
  logic [NUM_CMP-1:0] nxt_result;
  logic [NUM_CMP-1:0] evt;
  logic [NUM_CMP-1:0] w1c;
  logic [7:0] status;
  logic [31:0] nxt_dat;

  assign bus_req = cyc_i & stb_i & ~ack_ff;
  assign wr_req = bus_req & we_i & sel_i[0];

  // Comparator 3 has no amplifier, so its slot is tied off.
  assign amp_on = {{(NUM_CMP-NUM_AMP){1'b0}}, aux_ff.amp_connect};
  assign amp_tick = {{(NUM_CMP-NUM_AMP){1'b0}}, amp_tick2x_i};

  // Base comparator clock and its divide-by-two sample strobe.
  always_comb begin
    base_tick = ctrl_ff[0].opt ? pll_tick_i : 1'b1;
    div_tick = base_tick & div_ff;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_ff <= 1'b0;
    end else if (ce_i && base_tick) begin
      div_ff <= ~div_ff;
    end
  end

  // Per-comparator sample strobe, activity and edge events.
  always_comb begin
    for (int n = 0; n < NUM_CMP; n++) begin
      tick[n] = div_tick;
      if (amp_on[n]) begin
        // The strobe arrives at twice the amplifier rate.
        tick[n] = amp_tick[n];
      end
      // A reserved selector leaves the negative input floating, so the
      // comparator is treated as off rather than trusted.
      active[n] = ctrl_ff[n].en && (ctrl_ff[n].neg_sel != `ACMP_NEG_RSVD);
      nxt_result[n] = result_ff[n];
      if (!active[n]) begin
        nxt_result[n] = 1'b0;
      end else if (tick[n]) begin
        nxt_result[n] = cmp_raw_i[n];
      end
      evt[n] = 1'b0;
      if (active[n] && tick[n]) begin
        case (ctrl_ff[n].sense)
          `ACMP_SENSE_TOGGLE: evt[n] = cmp_raw_i[n] ^ result_ff[n];
          `ACMP_SENSE_FALL: evt[n] = result_ff[n] & ~cmp_raw_i[n];
          `ACMP_SENSE_RISE: evt[n] = ~result_ff[n] & cmp_raw_i[n];
          default: evt[n] = 1'b0;
        endcase
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      result_ff <= '0;
    end else if (ce_i) begin
      result_ff <= nxt_result;
    end
  end

  // Flags: a written one or a served vector clears, a new event wins.
  always_comb begin
    w1c = '0;
    if (wr_req && (adr_i == `ACMP_STATUS_ADDR)) begin
      w1c = dat_i[`ACMP_FLAG_LO +: NUM_CMP];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flag_ff <= '0;
    end else if (ce_i) begin
      for (int n = 0; n < NUM_CMP; n++) begin
        if (evt[n]) begin
          flag_ff[n] <= 1'b1;
        end else if (w1c[n] || (vector_ack_i[n] && ctrl_ff[n].ie)) begin
          flag_ff[n] <= 1'b0;
        end
      end
    end
  end

  // Control and auxiliary registers.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int n = 0; n < NUM_CMP; n++) begin
        ctrl_ff[n] <= `ACMP_CTRL_RESET;
      end
    end else if (ce_i && wr_req) begin
      if (adr_i == `ACMP_CTRL0_ADDR) begin
        ctrl_ff[0] <= dat_i[7:0];
      end else if (adr_i == `ACMP_CTRL1_ADDR) begin
        ctrl_ff[1] <= dat_i[7:0];
      end else if (adr_i == `ACMP_CTRL2_ADDR) begin
        // Bit 3 has no use on this comparator and reads zero.
        ctrl_ff[2] <= dat_i[7:0] & 8'hf7;
      end else if (adr_i == `ACMP_CTRL3_ADDR) begin
        ctrl_ff[3] <= dat_i[7:0] & 8'hf7;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      aux_ff <= `ACMP_AUX_RESET;
    end else if (ce_i && wr_req && (adr_i == `ACMP_AUX_ADDR)) begin
      aux_ff <= dat_i[7:0] & 8'h7f;
    end
  end

  // Registered outputs towards the analog side.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int n = 0; n < NUM_CMP; n++) begin
        ctrl_out_ff[n] <= `ACMP_CTRL_RESET;
      end
      ref_ff <= 2'h0;
      amp_ff <= '0;
      res_out_ff <= '0;
    end else if (ce_i) begin
      ctrl_out_ff <= ctrl_ff;
      ref_ff <= aux_ff.ref_sel;
      amp_ff <= aux_ff.amp_connect;
      res_out_ff <= nxt_result;
    end
  end

  // Dedicated interrupt lines and conversion triggers.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_ff <= '0;
      trig_ff <= '0;
    end else if (ce_i) begin
      for (int n = 0; n < NUM_CMP; n++) begin
        irq_ff[n] <= flag_ff[n] & ctrl_ff[n].ie;
      end
      trig_ff <= flag_ff;
    end
  end

  // Capture routing of comparator 1.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      capt_ff <= '0;
      capt_prev_ff <= 1'b0;
    end else if (ce_i) begin
      if (ctrl_ff[1].opt) begin
        capt_prev_ff <= nxt_result[1];
        capt_ff.level <= nxt_result[1];
        if (aux_ff.capt_edge) begin
          capt_ff.event_pulse <= ~capt_prev_ff & nxt_result[1];
          capt_ff.irq <= ~capt_prev_ff & nxt_result[1] & aux_ff.capt_mask;
        end else begin
          capt_ff.event_pulse <= capt_prev_ff & ~nxt_result[1];
          capt_ff.irq <= capt_prev_ff & ~nxt_result[1] & aux_ff.capt_mask;
        end
      end else begin
        // Nothing of comparator 1 reaches the capture output while routing is off.
        capt_ff <= '0;
        capt_prev_ff <= 1'b0;
      end
    end
  end

  // Read data path.
  always_comb begin
    status = {flag_ff, result_ff};
    nxt_dat = 32'h0000_0000;
    if (adr_i == `ACMP_CTRL0_ADDR) begin
      nxt_dat[7:0] = ctrl_ff[0];
    end else if (adr_i == `ACMP_CTRL1_ADDR) begin
      nxt_dat[7:0] = ctrl_ff[1];
    end else if (adr_i == `ACMP_CTRL2_ADDR) begin
      nxt_dat[7:0] = ctrl_ff[2];
    end else if (adr_i == `ACMP_CTRL3_ADDR) begin
      nxt_dat[7:0] = ctrl_ff[3];
    end else if (adr_i == `ACMP_STATUS_ADDR) begin
      nxt_dat[7:0] = status;
    end else if (adr_i == `ACMP_AUX_ADDR) begin
      nxt_dat[7:0] = aux_ff;
    end
  end

  // Every access, mapped or not, is answered one cycle after the strobe, or once ce_i is high again.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
      dat_ff <= 32'h0000_0000;
    end else if (ce_i) begin
      ack_ff <= bus_req;
      if (bus_req && !we_i) begin
        dat_ff <= nxt_dat;
      end
    end
  end

  assign dat_o = dat_ff;
  assign ack_o = ack_ff;
  assign cmp_ctrl_o = ctrl_out_ff;
  assign ref_sel_o = ref_ff;
  assign amp_connect_o = amp_ff;
  assign irq_o = irq_ff;
  assign conv_trig_o = trig_ff;
  assign result_o = res_out_ff;
  assign capture_o = capt_ff;

endmodule : analog_comparator_control

// *** tb/acmp_asserts.sv ***
// Port checker for the comparator control block.
// Ack timing is only checked while ce_i is high, since a low ce_i freezes it; read data is checked on any ack.
`timescale 1ns/100ps
`include "acmp_cfg.svh"
module acmp_asserts
  import acmp_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  input wire cmp_ctrl_t [NUM_CMP-1:0] cmp_ctrl_o,
  input wire logic [NUM_CMP-1:0] irq_o,
  input wire logic [NUM_CMP-1:0] conv_trig_o,
  input wire logic [NUM_CMP-1:0] result_o,
  input wire capture_t capture_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence up0;
    $rose(result_o[0]) && $past(cmp_ctrl_o[0].en) && cmp_ctrl_o[0].sense == `ACMP_SENSE_RISE;
  endsequence
  sequence flag0;
    ##[0:1] conv_trig_o[0];
  endsequence
  chk_ack_pulse: assert property (ack_o && ce_i |=> !ack_o) else $error("ack held too long");
  chk_ack_answer: assert property (cyc_i && stb_i && !ack_o && ce_i |=> ack_o) else $error("no ack");
  chk_read_upper: assert property (ack_o |-> dat_o[31:8] == 24'h0) else $error("upper data set");
  chk_rise_flag: assert property (up0 |-> flag0) else $error("rise gave no flag");
  chk_capt_off: assert property ((!cmp_ctrl_o[1].opt)[*3] |-> capture_o == '0) else $error("capture leak");
  chk_capt_edge: assert property (capture_o.event_pulse |-> capture_o.level != $past(capture_o.level))
    else $error("capture without edge");
  chk_capt_mask: assert property (capture_o.irq |-> capture_o.event_pulse) else $error("stray capture irq");
  for (genvar n = 0; n < NUM_CMP; n++) begin : g_cmp
    chk_irq_gated: assert property ((!cmp_ctrl_o[n].ie)[*2] |-> !irq_o[n]) else $error("irq not gated");
    chk_irq_flag: assert property (irq_o[n] |-> conv_trig_o[n]) else $error("irq without flag");
    chk_off_quiet: assert property ((!cmp_ctrl_o[n].en)[*3] |-> !$rose(conv_trig_o[n]))
      else $error("disabled comparator flagged");
  end
endmodule : acmp_asserts

bind analog_comparator_control acmp_asserts u_chk (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .cyc_i(cyc_i),
  .stb_i(stb_i), .dat_o(dat_o), .ack_o(ack_o), .cmp_ctrl_o(cmp_ctrl_o), .irq_o(irq_o),
  .conv_trig_o(conv_trig_o), .result_o(result_o), .capture_o(capture_o));

// *** tb/acmp_far_model.sv ***
// Analog side: input pins and reference levels in millivolts.
// Assumes the bench sets pin levels; an outcome lands one clock later.
`timescale 1ns/100ps
module acmp_far_model
  import acmp_pkg::*;
#(
  parameter int VREF_MV = 2560,
  parameter int DAC_MV = 1000,
  parameter int PIN_MV = 1500
)
(
  input wire logic clk_i,
  input wire cmp_ctrl_t [NUM_CMP-1:0] ctrl_i,
  input wire logic [1:0] ref_sel_i,
  input wire logic [NUM_CMP-1:0][15:0] pos_mv_i,
  output logic [NUM_CMP-1:0] raw_o
);
  function automatic int neg_mv(input logic [2:0] s);
    int v;
    v = VREF_MV + 256 * ref_sel_i;
    case (s)
      3'h0: return v * 100 / 640;
      3'h1: return v * 100 / 320;
      3'h2: return v * 100 / 213;
      3'h3: return v * 100 / 160;
      3'h4: return 1100;
      3'h5: return DAC_MV;
      default: return PIN_MV;
    endcase
  endfunction : neg_mv
  initial raw_o = '0;
  // An unpowered or reserved input gives no steady answer, so it toggles.
  always @(posedge clk_i) begin
    for (int n = 0; n < NUM_CMP; n++) begin
      if (!ctrl_i[n].en || ctrl_i[n].neg_sel == 3'h7) raw_o[n] <= ~raw_o[n];
      else raw_o[n] <= (int'(pos_mv_i[n]) > neg_mv(ctrl_i[n].neg_sel));
    end
  end
endmodule : acmp_far_model

// *** tb/tb.sv ***
// Bench for the comparator control block: Wishbone tasks and checks.
// Assumes the far-side model drives the raw comparator outcomes.
`timescale 1ns/100ps
`include "acmp_cfg.svh"
module tb;
  import acmp_pkg::*;
  logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, pll = 0, ce = 1;
  logic [7:0] adr_i = 8'h0;
  logic [3:0] sel_i = 4'h0, vack = 4'h0, raw, irq, trig, res;
  logic [31:0] dat_i = 32'h0, dat_o, rd;
  logic ack_o;
  logic [1:0] refs;
  logic [2:0] ampc, amp = 3'h0;
  cmp_ctrl_t [3:0] ctrl;
  capture_t cap;
  logic [3:0][15:0] pos = '0;
  int fails = 0, n_tests = 0, capt_evts = 0, capt_irqs = 0, evt0 = 0, irq0 = 0;
  analog_comparator_control DUT (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .cmp_raw_i(raw), .cmp_ctrl_o(ctrl), .ref_sel_o(refs), .amp_connect_o(ampc), .pll_tick_i(pll),
    .amp_tick2x_i(amp), .vector_ack_i(vack), .irq_o(irq), .conv_trig_o(trig), .result_o(res),
    .capture_o(cap));
  acmp_far_model u_far (.clk_i(clk_i), .ctrl_i(ctrl), .ref_sel_i(refs), .pos_mv_i(pos), .raw_o(raw));
  initial begin
    forever #10 clk_i = ~clk_i;
  end
  // Capture pulses last one cycle, so they are counted as they pass.
  always @(posedge clk_i) begin
    if (cap.event_pulse === 1'b1) capt_evts++;
    if (cap.irq === 1'b1) capt_irqs++;
  end
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : conclude
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // Entered just after a rising edge; leaves the bus idle for one cycle.
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [3:0] s);
    int k;
    k = 0;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= {24'h0, d};
    sel_i <= s;
    do begin
      @(posedge clk_i);
      k++;
    end while (ack_o !== 1'b1 && k < 20);
    rd = dat_o;
    if (k >= 20) begin
      fails++;
      conclude();
    end
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  endtask : wb
  task automatic rchk(input string nm, input logic [7:0] a, input logic [7:0] e);
    wb(1'b0, a, 8'h0, 4'h1);
    chk(nm, {24'h0, e}, rd);
  endtask : rchk
  task automatic settle();
    repeat (8) @(posedge clk_i);
  endtask : settle
  logic f;
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    for (int i = 0; i < 7; i++) rchk("reset value", 8'(i * 4), 8'h0);
    wb(1'b1, `ACMP_CTRL0_ADDR, 8'hff, 4'h1);
    rchk("ctrl0", `ACMP_CTRL0_ADDR, 8'hff);
    chk("ctrl copy", 32'hff, {24'h0, ctrl[0]});
    wb(1'b1, `ACMP_CTRL2_ADDR, 8'hff, 4'h1);
    rchk("ctrl2", `ACMP_CTRL2_ADDR, 8'hf7);
    wb(1'b1, `ACMP_CTRL3_ADDR, 8'hff, 4'he);
    rchk("ctrl3 no lane", `ACMP_CTRL3_ADDR, 8'h0);
    wb(1'b1, 8'h18, 8'hff, 4'h1);
    rchk("unmapped", 8'h18, 8'h0);
    wb(1'b1, `ACMP_AUX_ADDR, 8'hff, 4'h1);
    rchk("aux", `ACMP_AUX_ADDR, 8'h7f);
    chk("ref select", 32'h3, {30'h0, refs});
    chk("amp connect", 32'h7, {29'h0, ampc});
    wb(1'b1, `ACMP_AUX_ADDR, 8'h0, 4'h1);
    wb(1'b1, `ACMP_CTRL2_ADDR, 8'h0, 4'h1);
    for (int c = 0; c < 4; c++) begin
      wb(1'b1, `ACMP_CTRL0_ADDR, {2'b11, 2'(c), 4'h6}, 4'h1);
      settle();
      pos[0] <= 16'd3000;
      settle();
      f = (c == 0 || c == 3);
      // The result follows the input whatever the sense code, even the reserved one.
      rchk("status rise", `ACMP_STATUS_ADDR, {3'h0, f, 3'h0, 1'b1});
      chk("irq rise", {31'h0, f}, {31'h0, irq[0]});
      chk("trigger rise", {31'h0, f}, {31'h0, trig[0]});
      chk("result out", 32'h1, {31'h0, res[0]});
      vack <= 4'h1;
      @(posedge clk_i);
      vack <= 4'h0;
      pos[0] <= 16'd0;
      settle();
      f = (c == 0 || c == 2);
      rchk("status fall", `ACMP_STATUS_ADDR, {3'h0, f, 4'h0});
      wb(1'b1, `ACMP_STATUS_ADDR, 8'hf0, 4'h1);
    end
    rchk("status cleared", `ACMP_STATUS_ADDR, 8'h0);
    // With the PLL tick silent the comparator must not sample at all.
    wb(1'b1, `ACMP_CTRL0_ADDR, 8'h8e, 4'h1);
    pos[0] <= 16'd3000;
    settle();
    rchk("pll idle", `ACMP_STATUS_ADDR, 8'h0);
    repeat (4) begin
      pll <= 1'b1;
      @(posedge clk_i);
      pll <= 1'b0;
      @(posedge clk_i);
    end
    settle();
    rchk("pll ticks", `ACMP_STATUS_ADDR, 8'h11);
    // The clock select is shared, so the I/O clock goes back before comparator 1 is used.
    wb(1'b1, `ACMP_CTRL0_ADDR, 8'h86, 4'h1);
    wb(1'b1, `ACMP_AUX_ADDR, 8'h03, 4'h1);
    wb(1'b1, `ACMP_CTRL1_ADDR, 8'h8e, 4'h1);
    settle();
    evt0 = capt_evts;
    irq0 = capt_irqs;
    pos[1] <= 16'd3000;
    settle();
    chk("capture level", 32'h1, {31'h0, cap.level});
    chk("capture rise", 32'h1, 32'(capt_evts - evt0));
    chk("capture irq", 32'h1, 32'(capt_irqs - irq0));
    wb(1'b1, `ACMP_CTRL1_ADDR, 8'h86, 4'h1);
    pos[1] <= 16'd0;
    settle();
    chk("capture off", 32'h0, {29'h0, cap});
    // A low clock enable must freeze the result while the input falls.
    ce <= 1'b0;
    pos[0] <= 16'd0;
    settle();
    chk("frozen result", 32'h1, {31'h0, res[0]});
    ce <= 1'b1;
    settle();
    chk("thawed result", 32'h0, {31'h0, res[0]});
    // With amplifier 0 connected only its strobe may sample comparator 0.
    wb(1'b1, `ACMP_AUX_ADDR, 8'h10, 4'h1);
    pos[0] <= 16'd3000;
    settle();
    chk("no amp strobe", 32'h0, {31'h0, res[0]});
    amp <= 3'h1;
    @(posedge clk_i);
    amp <= 3'h0;
    settle();
    chk("amp strobe", 32'h1, {31'h0, res[0]});
    conclude();
  end
endmodule : tb
